/* File: src/psq_pkg.sv */
`default_nettype none
package psq_pkg;
  // ************************************************
  // pointer and memory geometry
  // ************************************************
  localparam int IP_W = 11;
  localparam int TGT_W = 10;
  localparam int OPC_W = 5;
  localparam int STK_DEPTH = 3;
  localparam int STK_W = IP_W + 1;
  localparam int LVL_W = 2;
  localparam int ROM_WORDS = 2040;
  localparam int INSTR_W = 16;

  localparam logic [IP_W-1:0] RESET_ADDR = 11'h000;
  localparam logic [IP_W-1:0] IRQ_VECTOR = 11'h001;
  localparam logic [IP_W-1:0] IP_STEP = 11'h001;
  localparam logic [IP_W-1:0] LOW_PAGE_LAST = 11'h3ff;
  localparam logic [IP_W-1:0] HIGH_PAGE_FIRST = 11'h400;
  localparam logic [IP_W-1:0] ROM_LAST_ADDR = 11'h7f7;

  // ************************************************
  // jump operation codes, one per page
  // ************************************************
  localparam logic [OPC_W-1:0] JUMP_LOW_OPC = 5'h06;
  localparam logic [OPC_W-1:0] JUMP_HIGH_OPC = 5'h02;

  localparam logic [LVL_W-1:0] LVL_EMPTY = 2'h0;
  localparam logic [LVL_W-1:0] LVL_FULL = 2'h3;
  localparam logic [LVL_W-1:0] LVL_STEP = 2'h1;
endpackage
`default_nettype wire

/* File: src/psq_return_stack.sv */
`default_nettype none
module psq_return_stack
  import psq_pkg::*;
#(
  parameter int DEPTH = psq_pkg::STK_DEPTH
) (
  input  wire logic                      ref_clk,  // system clock
  input  wire logic                      nrst,     // async reset, low
  input  wire logic                      push,     // store an entry
  input  wire logic                      pop,      // take the top entry
  input  wire logic [psq_pkg::STK_W-1:0] wr_data,  // {skip, address}
  output logic      [psq_pkg::STK_W-1:0] top_data  // entry on top
);
  import psq_pkg::*;

  // ************************************************
  // circular storage
  // ************************************************
  // a push past the last level simply wraps and overwrites the oldest
  // entry; no overflow flag, software must not nest that deep
  localparam int IDX_W = $clog2(DEPTH);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);
  localparam logic [IDX_W-1:0] IDX_ONE = IDX_W'(1);

  logic [STK_W-1:0] mem_q [DEPTH];
  logic [IDX_W-1:0] wp_q;
  logic [IDX_W-1:0] wp_d;
  wire  [IDX_W-1:0] wp_inc = (wp_q == IDX_LAST) ? '0 : wp_q + IDX_ONE;
  wire  [IDX_W-1:0] wp_dec = (wp_q == '0) ? IDX_LAST : wp_q - IDX_ONE;

  assign wp_d = push ? wp_inc : (pop ? wp_dec : wp_q);
  assign top_data = mem_q[wp_dec];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
    end else begin
      wp_q <= wp_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      wire wr_here = push && (wp_q == IDX_W'(gi));
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          mem_q[gi] <= '0;
        end else if (wr_here) begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // ************************************************
  // checks
  // ************************************************
  wrap_push_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    push && wp_q == IDX_LAST |=> wp_q == '0)
    else $error("push did not wrap to the first level");

  push_top_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    push |=> top_data == $past(wr_data))
    else $error("pushed entry not on top");
endmodule
`default_nettype wire

/* File: src/psq_sequencer.sv */
`default_nettype none
module psq_sequencer
  import psq_pkg::*;
(
  input  wire logic                      ref_clk,             // system clock
  input  wire logic                      nrst,                // async, low
  input  wire logic                      clk_en,              // freezes state
  input  wire logic                      exec,                // instr retires
  input  wire logic [psq_pkg::OPC_W-1:0] opcode,              // decoded opcode
  input  wire logic                      jump_instr,          // jump retires
  input  wire logic                      call_instr,          // call retires
  input  wire logic                      return_instr,        // plain return
  input  wire logic                      return_skip,         // return, skip
  input  wire logic                      skip_true,           // skip cond met
  input  wire logic [psq_pkg::TGT_W-1:0] target,              // operand addr
  input  wire logic                      irq_accept,          // irq taken
  output logic      [psq_pkg::IP_W-1:0]  instruction_pointer, // fetch addr
  output logic                           nop_slot,            // instr voided
  output logic      [psq_pkg::LVL_W-1:0] stack_level,         // levels in use
  output logic                           upper_page,          // ptr in page 1
  output logic                           rom_addr_ok          // ptr in rom
);
  import psq_pkg::*;

  // ************************************************
  // state
  // ************************************************
  logic [IP_W-1:0]  ip_q;
  logic [IP_W-1:0]  ip_d;
  logic             nop_q;
  logic             nop_d;
  logic [LVL_W-1:0] lvl_q;
  logic [LVL_W-1:0] lvl_d;
  logic             page_q;
  logic             rom_ok_q;

  // ************************************************
  // decode of the retiring instruction
  // ************************************************
  // a voided instruction still retires but its effects are dropped
  wire live = exec && !nop_q;
  wire go_irq = clk_en && irq_accept;
  wire go_jump = live && jump_instr;
  wire go_call = live && call_instr;
  wire go_ret = live && (return_instr || return_skip);
  wire transfer = jump_instr || call_instr || return_instr || return_skip;
  wire skip_now = live && skip_true && !transfer;
  wire page_bit = (opcode == JUMP_HIGH_OPC);

  wire [IP_W-1:0] ip_inc = ip_q + IP_STEP;
  wire [IP_W-1:0] jump_addr = {page_bit, target};
  wire [IP_W-1:0] call_addr = {1'b0, target};

  // ************************************************
  // return stack, shared by calls and interrupts
  // ************************************************
  // the interrupt takes a level like a call, so nesting depth left to
  // subroutines shrinks while a handler runs
  wire             stk_push = go_irq || (clk_en && go_call);
  wire             stk_pop = clk_en && go_ret && !irq_accept;
  wire             push_skip = irq_accept && skip_now;
  wire [STK_W-1:0] push_data = {push_skip, ip_inc};
  wire [STK_W-1:0] pop_data;
  wire [IP_W-1:0]  pop_addr = pop_data[IP_W-1:0];
  wire             pop_skip = pop_data[STK_W-1];

  psq_return_stack #(
    .DEPTH (STK_DEPTH)
  ) u_stack (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .push     (stk_push),
    .pop      (stk_pop),
    .wr_data  (push_data),
    .top_data (pop_data)
  );

  // ************************************************
  // next pointer
  // ************************************************
  // an interrupt overrides whatever transfer retires with it
  always_comb begin
    ip_d = ip_q;
    if (irq_accept) begin
      ip_d = IRQ_VECTOR;
    end else if (!exec) begin
      ip_d = ip_q;
    end else if (go_jump) begin
      ip_d = jump_addr;
    end else if (go_call) begin
      ip_d = call_addr;
    end else if (go_ret) begin
      ip_d = pop_addr;
    end else begin
      ip_d = ip_inc;
    end
  end

  // ************************************************
  // void flag for the slot after a true skip
  // ************************************************
  always_comb begin
    nop_d = nop_q;
    if (irq_accept) begin
      nop_d = 1'b0;
    end else if (!exec) begin
      nop_d = nop_q;
    end else if (go_ret) begin
      // the saved judgement voids the first instruction after return
      nop_d = return_skip || pop_skip;
    end else begin
      nop_d = skip_now;
    end
  end

  // ************************************************
  // occupancy, saturating to match the wrapping store
  // ************************************************
  wire lvl_up = stk_push && (lvl_q != LVL_FULL);
  wire lvl_dn = stk_pop && !stk_push && (lvl_q != LVL_EMPTY);
  assign lvl_d = lvl_up ? lvl_q + LVL_STEP :
                 (lvl_dn ? lvl_q - LVL_STEP : lvl_q);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ip_q <= RESET_ADDR;
      nop_q <= 1'b0;
      lvl_q <= LVL_EMPTY;
      page_q <= 1'b0;
      rom_ok_q <= 1'b1;
    end else if (clk_en) begin
      ip_q <= ip_d;
      nop_q <= nop_d;
      lvl_q <= lvl_d;
      page_q <= (ip_d >= HIGH_PAGE_FIRST);
      rom_ok_q <= (ip_d <= ROM_LAST_ADDR);
    end
  end

  assign instruction_pointer = ip_q;
  assign nop_slot = nop_q;
  assign stack_level = lvl_q;
  assign upper_page = page_q;
  assign rom_addr_ok = rom_ok_q;

  // ************************************************
  // checks
  // ************************************************
  wire plain_go = clk_en && exec && !irq_accept && (!live || !transfer);
  wire jlo_go = clk_en && go_jump && !irq_accept
                && opcode == JUMP_LOW_OPC;
  wire jhi_go = clk_en && go_jump && !irq_accept
                && opcode == JUMP_HIGH_OPC;
  wire call_go = clk_en && go_call && !irq_accept;
  wire ret_go = clk_en && go_ret && !irq_accept;
  wire void_go = clk_en && exec && nop_q && !irq_accept;
  wire idle_go = clk_en && !exec && !irq_accept;
  wire xfer_go = jlo_go || jhi_go || call_go;

  // the *_go terms exclude an interrupt in the same cycle, since it
  // overrides every other outcome; irq_vector_a, irq_skip_a and irq_push_a cover that case
  step_one_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    plain_go |=> ip_q == $past(ip_q) + IP_STEP)
    else $error("pointer did not advance by one");

  void_clear_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    void_go |=> !nop_q && ip_q == $past(ip_q) + IP_STEP)
    else $error("voided slot did not step and clear");

  idle_hold_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    idle_go |=> $stable(ip_q) && $stable(nop_q) && $stable(lvl_q))
    else $error("state moved with nothing retiring");

  jump_low_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    jlo_go |=> ip_q == {1'b0, $past(target)} && !page_q)
    else $error("low page jump went astray");

  jump_high_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    jhi_go |=> ip_q[IP_W-1] && ip_q[TGT_W-1:0] == $past(target))
    else $error("high page jump lost the page bit");

  page_set_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    jhi_go |=> page_q)
    else $error("high page jump left page flag low");

  jump_stack_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (jlo_go || jhi_go) |=> $stable(lvl_q))
    else $error("jump touched the stack");

  xfer_live_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    xfer_go |=> !nop_q)
    else $error("jump or call voided the next slot");

  call_page_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    call_go |=> ip_q == {1'b0, $past(target)})
    else $error("call target not in lower page");

  irq_vector_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    go_irq |=> ip_q == IRQ_VECTOR && !nop_q)
    else $error("interrupt did not vector to 1");

  skip_void_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (clk_en && skip_now && !irq_accept)
      |=> nop_q && ip_q == $past(ip_q) + IP_STEP)
    else $error("skip did not void the next slot");

  call_return_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    call_go ##1 ret_go |=> ip_q == $past(ip_q, 2) + IP_STEP)
    else $error("return did not restore caller");

  ret_pop_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    ret_go |=> ip_q == $past(pop_addr))
    else $error("return did not load the top entry");

  ret_skip_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ret_go && return_skip) |=> nop_q)
    else $error("skipping return did not void next slot");

  ret_flag_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ret_go && !return_skip) |=> nop_q == $past(pop_skip))
    else $error("plain return lost the saved skip bit");

  irq_skip_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (go_irq && skip_now) ##1 (ret_go && return_instr && !return_skip)
      |=> nop_q && ip_q == $past(ip_q, 2) + IP_STEP)
    else $error("skip judgement not kept over interrupt");

  irq_push_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    go_irq ##1 ret_go |=> ip_q == $past(ip_q, 2) + IP_STEP)
    else $error("interrupt return address wrong");

  freeze_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !clk_en |=> $stable(ip_q) && $stable(nop_q) && $stable(lvl_q))
    else $error("state moved with clock enable low");

  stack_freeze_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !clk_en |=> $stable(pop_data))
    else $error("stack moved with clock enable low");

  lvl_push_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (stk_push && lvl_q != LVL_FULL) |=> lvl_q == $past(lvl_q) + LVL_STEP)
    else $error("push did not raise the level");

  lvl_pop_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (stk_pop && !stk_push && lvl_q != LVL_EMPTY)
      |=> lvl_q == $past(lvl_q) - LVL_STEP)
    else $error("pop did not lower the level");

  level_cap_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (lvl_q == LVL_FULL && stk_push && !stk_pop) |=> lvl_q == LVL_FULL)
    else $error("stack level passed three");

  rom_flag_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    rom_ok_q == (ip_q <= ROM_LAST_ADDR) && page_q == ip_q[IP_W-1])
    else $error("range flags disagree with pointer");

  rom_end_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (plain_go && ip_q == ROM_LAST_ADDR) |=> !rom_ok_q)
    else $error("pointer past rom end still flagged ok");

  page_split_a: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    page_q == (ip_q > LOW_PAGE_LAST))
    else $error("page flag disagrees with lower page end");
endmodule
`default_nettype wire

/* File: verification/psq_decoder_model.sv */
`default_nettype none
module psq_decoder_model
  import psq_pkg::*;
(
  output logic                      clk_en,       // run enable
  output logic                      exec,         // instr retires
  output logic [psq_pkg::OPC_W-1:0] opcode,       // decoded opcode
  output logic                      jump_instr,   // jump retires
  output logic                      call_instr,   // call retires
  output logic                      return_instr, // plain return
  output logic                      return_skip,  // return and skip
  output logic                      skip_true,    // skip condition
  output logic [psq_pkg::TGT_W-1:0] target,       // operand address
  output logic                      irq_accept    // interrupt taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // kinds: 0 plain, 1 jump low, 2 jump high, 3 call, 4/5 return
  // ************************************************
  // strobes stay low with no retiring instr, like a real decoder
  task automatic drive(input logic en, ex, input logic [2:0] k,
                       input logic [TGT_W-1:0] t, input logic sk, irq);
    clk_en       = en;
    exec         = ex;
    opcode       = (k == 3'd1) ? JUMP_LOW_OPC :
                   (k == 3'd2) ? JUMP_HIGH_OPC : 5'h1c;
    jump_instr   = ex && (k == 3'd1 || k == 3'd2);
    call_instr   = ex && (k == 3'd3);
    return_instr = ex && (k == 3'd4); // caller may nest deeper than 3
    return_skip  = ex && (k == 3'd5);
    skip_true    = ex && sk;
    target       = t;
    irq_accept   = irq;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psq_pkg::*;
  logic             ref_clk, nrst, clk_en, exec, jump_instr, call_instr;
  logic             return_instr, return_skip, skip_true, irq_accept;
  logic             nop_slot, upper_page, rom_addr_ok, m_nop;
  logic [OPC_W-1:0] opcode;
  logic [TGT_W-1:0] target;
  logic [IP_W-1:0]  ip, m_ip;
  logic [LVL_W-1:0] lvl, m_lvl;
  logic [STK_W-1:0] m_stk [STK_DEPTH];
  int               m_sp, miscompares, total_checks;

  always #12.5 ref_clk = ~ref_clk;

  psq_decoder_model drv (.clk_en(clk_en), .exec(exec), .opcode(opcode),
    .jump_instr(jump_instr), .call_instr(call_instr),
    .return_instr(return_instr), .return_skip(return_skip),
    .skip_true(skip_true), .target(target), .irq_accept(irq_accept));
  psq_sequencer DUT (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .exec(exec), .opcode(opcode), .jump_instr(jump_instr),
    .call_instr(call_instr), .return_instr(return_instr),
    .return_skip(return_skip), .skip_true(skip_true), .target(target),
    .irq_accept(irq_accept), .instruction_pointer(ip),
    .nop_slot(nop_slot), .stack_level(lvl), .upper_page(upper_page),
    .rom_addr_ok(rom_addr_ok));

  // ************************************************
  // reference model
  // ************************************************
  function automatic void push(logic [STK_W-1:0] e);
    m_stk[m_sp] = e;
    m_sp = (m_sp + 1) % STK_DEPTH;
    if (m_lvl != LVL_FULL) m_lvl = m_lvl + LVL_STEP;
  endfunction

  function automatic void predict(logic ex, logic [2:0] k,
                                  logic [TGT_W-1:0] t, logic sk, irq);
    logic [STK_W-1:0] e;
    logic             live;
    live = ex && !m_nop && (k == 3'd0);
    if (irq) begin
      push({live && sk, m_ip + IP_STEP});
      m_ip = IRQ_VECTOR;
      m_nop = 1'b0;
    end else if (m_nop) begin
      m_ip = m_ip + IP_STEP;
      m_nop = 1'b0;
    end else begin
      case (k)
        3'd1, 3'd2: m_ip = {k == 3'd2, t};
        3'd3: begin
          push({1'b0, m_ip + IP_STEP});
          m_ip = {1'b0, t};
        end
        3'd4, 3'd5: begin
          m_sp = (m_sp + STK_DEPTH - 1) % STK_DEPTH;
          e = m_stk[m_sp];
          if (m_lvl != LVL_EMPTY) m_lvl = m_lvl - LVL_STEP;
          m_ip = e[IP_W-1:0];
          m_nop = (k == 3'd5) || e[IP_W];
        end
        default: begin
          m_ip = m_ip + IP_STEP;
          m_nop = sk;
        end
      endcase
    end
  endfunction

  task automatic reset_model();
    m_ip = RESET_ADDR;
    m_nop = 1'b0;
    m_lvl = LVL_EMPTY;
    m_sp = 0;
  endtask

  task automatic check();
    `CHK(ip, m_ip)
    `CHK(nop_slot, m_nop)
    `CHK(lvl, m_lvl)
    `CHK(upper_page, m_ip >= HIGH_PAGE_FIRST)
    `CHK(rom_addr_ok, m_ip <= ROM_LAST_ADDR)
  endtask

  task automatic step(input logic en, ex, input logic [2:0] k,
                      input logic [TGT_W-1:0] t, input logic sk, irq);
    drv.drive(en, ex, k, t, sk, irq);
    if (en && (ex || irq)) predict(ex, k, t, sk, irq);
    @(posedge ref_clk);
    #1;
    check();
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  initial begin
    int k;
    ref_clk = 1'b0;
    nrst = 1'b0;
    miscompares = 0;
    total_checks = 0;
    drv.drive(0, 0, 0, 0, 0, 0);
    void'($urandom(20841));
    reset_model();
    repeat (10) @(posedge ref_clk);
    #1;
    check();
    nrst = 1'b1;
    step(0, 1, 3, 10'h155, 0, 0);             // frozen
    step(1, 1, 1, 10'h3ff, 0, 0);
    step(1, 1, 2, 10'h3f7, 0, 0);
    step(1, 1, 0, 10'h000, 0, 0);             // past rom end
    step(1, 1, 2, 10'h000, 1, 0);
    for (k = 0; k < 4; k++) step(1, 1, 3, TGT_W'(k + 10'h2a0), 0, 0);
    for (k = 0; k < 3; k++) step(1, 1, 4, 0, 0, 0);
    step(1, 1, 0, 10'h000, 1, 0);
    step(1, 1, 1, 10'h0aa, 0, 0);             // voided jump
    step(1, 1, 0, 10'h000, 1, 1);
    step(1, 1, 4, 0, 0, 0);                   // skip restored
    step(1, 1, 3, 10'h3c0, 0, 0);
    step(1, 1, 5, 0, 0, 0);
    step(1, 0, 0, 0, 0, 1);
    step(1, 1, 3, 10'h111, 0, 1);             // irq beats call
    // pops on an empty stack read stale data, so they are left out
    repeat (3000) begin
      k = $urandom_range(0, 5);
      if (k >= 4 && m_lvl == LVL_EMPTY) k = 0;
      step($urandom_range(0, 7) != 0, $urandom_range(0, 3) != 0, 3'(k),
           TGT_W'($urandom), 1'($urandom_range(0, 1)),
           $urandom_range(0, 15) == 0);
    end
    nrst = 1'b0;
    reset_model();
    #1;
    check();
    @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    step(1, 1, 0, 10'h000, 0, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
